/* rtl/pvm_pin_arb.sv */
// fixed priority selection of the function that drives one pin
`timescale 1ns/100ps
module pvm_pin_arb (
  input wire logic [5:0] src_en_in,
  input wire logic [5:0] src_do_in,
  input wire logic [5:0] src_oe_in,
  input wire logic gpio_do_in,
  input wire logic gpio_oe_in,
  output logic pin_do_out,
  output logic pin_oe_out
);
  // walk from lowest priority upward so the highest claimant lands last
  always_comb begin
    pin_do_out = gpio_do_in;
    pin_oe_out = gpio_oe_in;
    for (int i = pvm_pkg::PVM_NSRC - 1; i >= 0; i--) begin
      if (src_en_in[i]) begin
        pin_do_out = src_do_in[i];
        pin_oe_out = src_oe_in[i];
      end
    end
  end
endmodule

/* rtl/pvm_pkg.sv */
// constants shared by the port v pin function mux
package pvm_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [31:0] PVM_LATCH_ADDR = 32'h0000_0298;
  localparam logic [7:0] PVM_LATCH_RST = 8'h00;
  localparam int PVM_PORT_W = 8;
  // ----------------------------------------------------------------
  // ahb-lite codes
  // ----------------------------------------------------------------
  localparam logic [1:0] PVM_HTRANS_NONSEQ = 2'h2;
  localparam logic PVM_HRESP_OKAY = 1'h0;
  // ----------------------------------------------------------------
  // arbitration slots, lowest index wins
  // ----------------------------------------------------------------
  localparam int PVM_NSRC = 6;
  localparam int PVM_SLOT_STALL = 0;
  localparam int PVM_SLOT_MOTOR = 1;
  localparam int PVM_SLOT_C = 2;
  localparam int PVM_SLOT_D = 3;
  localparam int PVM_SLOT_E = 4;
  localparam int PVM_SLOT_F = 5;
endpackage

/* rtl/pvm_top.sv */
// port v data latch, ahb-lite slave and per-pin function arbitration
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/100ps
// Summary of operation
// [RULE1] eight-bit latch at 0x0298, reset zero
// [RULE2] read gives latch if output, else pin
// [RULE3] unclaimed pin is plain general purpose io
// [RULE4] pins 7,5: stall, motor, then io
// [RULE5] pins 6,4: stall, motor, timers, io
// [RULE6] second timer wins only when channel enabled
// [RULE7] pin 3: stall, motor, sda, channel seven, ss
// [RULE8] pin 2: stall, motor, timers, sck, channel six
// [RULE9] pin 1: stall, motor, mosi, pwm5
// [RULE10] input capture needs outputs off, slew clear
// [RULE11] output mode drives last written latch bit
module pvm_top (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  input wire logic [7:0] port_v_direction_in,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_out,
  output logic [7:0] pin_level_out,
  input wire logic [7:0] stall_detect_unit_en_in,
  input wire logic [7:0] stall_detect_unit_do_in,
  input wire logic [7:0] motor_pwm_en_in,
  input wire logic [7:0] motor_pwm_do_in,
  input wire logic [7:0] first_timer_unit_en_in,
  input wire logic [7:0] first_timer_unit_do_in,
  input wire logic [7:0] second_timer_unit_en_in,
  input wire logic [7:0] second_timer_unit_chan_en_in,
  input wire logic [7:0] second_timer_unit_do_in,
  input wire logic i2c_sda_en_in,
  input wire logic i2c_sda_do_in,
  input wire logic i2c_sda_oe_in,
  input wire logic pulse_channel_seven_en_in,
  input wire logic pulse_channel_seven_do_in,
  input wire logic pulse_channel_six_en_in,
  input wire logic pulse_channel_six_do_in,
  input wire logic pulse_channel_five_en_in,
  input wire logic pulse_channel_five_do_in,
  input wire logic [2:0] spi_en_in,
  input wire logic [2:0] spi_do_in,
  input wire logic [2:0] spi_oe_in
);
  // spi bit 0 is ss on pin 3, bit 1 sck on pin 2, bit 2 mosi on pin 1

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  function automatic logic hits_latch(input logic [31:0] addr);
    hits_latch = (addr == pvm_pkg::PVM_LATCH_ADDR);
  endfunction

  logic [7:0] latch_q, latch_d;
  logic wr_pend_q, wr_pend_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic hreadyout_q, hresp_q;
  logic [7:0] pin_meta_q, pin_sync_q;
  logic [7:0] pin_do_q, pin_do_d, pin_oe_q, pin_oe_d;
  logic take;
  logic [7:0] latch_view;

  assign take = hsel_in && hready_in && htrans_in[1];

  always_comb begin
    latch_d = latch_q;
    wr_pend_d = take && hwrite_in && hits_latch(haddr_in);
    if (wr_pend_q) begin
      latch_d = hwdata_in[7:0]; // see [RULE1]
    end
    // forward a write landing now so back-to-back read sees it
    latch_view = wr_pend_q ? hwdata_in[7:0] : latch_q;
    hrdata_d = hrdata_q;
    if (take && !hwrite_in) begin
      hrdata_d = 32'h0000_0000;
      if (hits_latch(haddr_in)) begin
        for (int i = 0; i < pvm_pkg::PVM_PORT_W; i++) begin
          hrdata_d[i] = port_v_direction_in[i] ? latch_view[i] : pin_sync_q[i]; // see [RULE2]
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      latch_q <= pvm_pkg::PVM_LATCH_RST; // see [RULE1]
      wr_pend_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q <= pvm_pkg::PVM_HRESP_OKAY;
    end else begin
      latch_q <= latch_d;
      wr_pend_q <= wr_pend_d;
      hrdata_q <= hrdata_d;
      hreadyout_q <= 1'b1;
      hresp_q <= pvm_pkg::PVM_HRESP_OKAY;
    end
  end

  // ----------------------------------------------------------------
  // pin input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_meta_q <= 8'h00;
      pin_sync_q <= 8'h00;
    end else begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // candidate functions per pin
  // ----------------------------------------------------------------
  logic [5:0] cand_en [8];
  logic [5:0] cand_do [8];
  logic [5:0] cand_oe [8];
  logic [7:0] arb_do, arb_oe;

  always_comb begin
    for (int p = 0; p < pvm_pkg::PVM_PORT_W; p++) begin
      cand_en[p] = 6'h00;
      cand_do[p] = 6'h00;
      cand_oe[p] = 6'h00;
      // stall detector and motor driver top every chain; both force output
      cand_en[p][pvm_pkg::PVM_SLOT_STALL] = stall_detect_unit_en_in[p]; // see [RULE4]
      cand_do[p][pvm_pkg::PVM_SLOT_STALL] = stall_detect_unit_do_in[p];
      cand_oe[p][pvm_pkg::PVM_SLOT_STALL] = 1'b1;
      cand_en[p][pvm_pkg::PVM_SLOT_MOTOR] = motor_pwm_en_in[p];
      cand_do[p][pvm_pkg::PVM_SLOT_MOTOR] = motor_pwm_do_in[p];
      cand_oe[p][pvm_pkg::PVM_SLOT_MOTOR] = 1'b1;
    end
    // timer outputs on pins 6, 4 and 2; the second timer needs its channel on
    for (int p = 2; p <= 6; p += 2) begin
      cand_en[p][pvm_pkg::PVM_SLOT_C] = first_timer_unit_en_in[p]; // see [RULE5]
      cand_do[p][pvm_pkg::PVM_SLOT_C] = first_timer_unit_do_in[p];
      cand_oe[p][pvm_pkg::PVM_SLOT_C] = 1'b1;
      cand_en[p][pvm_pkg::PVM_SLOT_D] = second_timer_unit_en_in[p]
                                        && second_timer_unit_chan_en_in[p]; // see [RULE6]
      cand_do[p][pvm_pkg::PVM_SLOT_D] = second_timer_unit_do_in[p];
      cand_oe[p][pvm_pkg::PVM_SLOT_D] = 1'b1;
    end
    // pin 2 continues with sck then pulse channel six, see [RULE8]
    cand_en[2][pvm_pkg::PVM_SLOT_E] = spi_en_in[1];
    cand_do[2][pvm_pkg::PVM_SLOT_E] = spi_do_in[1];
    cand_oe[2][pvm_pkg::PVM_SLOT_E] = spi_oe_in[1];
    cand_en[2][pvm_pkg::PVM_SLOT_F] = pulse_channel_six_en_in;
    cand_do[2][pvm_pkg::PVM_SLOT_F] = pulse_channel_six_do_in;
    cand_oe[2][pvm_pkg::PVM_SLOT_F] = 1'b1;
    // pin 3: sda, pulse channel seven, ss, see [RULE7]
    cand_en[3][pvm_pkg::PVM_SLOT_C] = i2c_sda_en_in;
    cand_do[3][pvm_pkg::PVM_SLOT_C] = i2c_sda_do_in;
    cand_oe[3][pvm_pkg::PVM_SLOT_C] = i2c_sda_oe_in;
    cand_en[3][pvm_pkg::PVM_SLOT_D] = pulse_channel_seven_en_in;
    cand_do[3][pvm_pkg::PVM_SLOT_D] = pulse_channel_seven_do_in;
    cand_oe[3][pvm_pkg::PVM_SLOT_D] = 1'b1;
    cand_en[3][pvm_pkg::PVM_SLOT_E] = spi_en_in[0];
    cand_do[3][pvm_pkg::PVM_SLOT_E] = spi_do_in[0];
    cand_oe[3][pvm_pkg::PVM_SLOT_E] = spi_oe_in[0];
    // pin 1: mosi then pwm5, see [RULE9]
    cand_en[1][pvm_pkg::PVM_SLOT_C] = spi_en_in[2];
    cand_do[1][pvm_pkg::PVM_SLOT_C] = spi_do_in[2];
    cand_oe[1][pvm_pkg::PVM_SLOT_C] = spi_oe_in[2];
    cand_en[1][pvm_pkg::PVM_SLOT_D] = pulse_channel_five_en_in;
    cand_do[1][pvm_pkg::PVM_SLOT_D] = pulse_channel_five_do_in;
    cand_oe[1][pvm_pkg::PVM_SLOT_D] = 1'b1;
  end

  // input capture on a second timer pin relies on software having
  // switched every output function of that channel off, see [RULE10]
  for (genvar g = 0; g < 8; g++) begin : g_pin
    pvm_pin_arb u_arb (
      .src_en_in(cand_en[g]),
      .src_do_in(cand_do[g]),
      .src_oe_in(cand_oe[g]),
      .gpio_do_in(latch_q[g]), // see [RULE11]
      .gpio_oe_in(port_v_direction_in[g]), // see [RULE3]
      .pin_do_out(arb_do[g]),
      .pin_oe_out(arb_oe[g])
    );
  end

  // ----------------------------------------------------------------
  // registered pin drive
  // ----------------------------------------------------------------
  always_comb begin
    pin_do_d = arb_do;
    pin_oe_d = arb_oe;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_do_q <= 8'h00;
      pin_oe_q <= 8'h00;
    end else begin
      pin_do_q <= pin_do_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  assign hreadyout_out = hreadyout_q;
  assign hresp_out = hresp_q;
  assign hrdata_out = hrdata_q;
  assign pin_out = pin_do_q;
  assign pin_oe_out = pin_oe_q;
  assign pin_level_out = pin_sync_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_wr_addr;
    take && hwrite_in && hits_latch(haddr_in);
  endsequence
  sequence s_rd_addr;
    take && !hwrite_in && hits_latch(haddr_in) && (port_v_direction_in == 8'hff);
  endsequence

  chk_latch_write: assert property (s_wr_addr ##1 1'b1 // see [RULE1]
      |=> latch_q == $past(hwdata_in[7:0]))
    else $error("latch did not take written byte");
  // covers plain reads and a read whose address phase meets a write data phase
  chk_read_latch: assert property (s_rd_addr |=> hrdata_q[7:0] == latch_q) // see [RULE2]
    else $error("read of output pins did not return latch");
  chk_read_pin: assert property (take && !hwrite_in && hits_latch(haddr_in) // see [RULE2]
      && port_v_direction_in == 8'h00 |=> hrdata_q == {24'h000000, $past(pin_sync_q)})
    else $error("read of input pins did not return pin level");
  chk_gpio_idle: assert property (!stall_detect_unit_en_in[7] && !motor_pwm_en_in[7] // see [RULE3]
      |=> pin_oe_q[7] == $past(port_v_direction_in[7]))
    else $error("unclaimed pin not under direction control");
  chk_stall_first: assert property (stall_detect_unit_en_in[5] // see [RULE4]
      |=> pin_out[5] == $past(stall_detect_unit_do_in[5]) && pin_oe_q[5])
    else $error("stall detector lost pin 5");
  chk_timer_order: assert property (!stall_detect_unit_en_in[6] // see [RULE5]
      && !motor_pwm_en_in[6] && first_timer_unit_en_in[6]
      |=> pin_out[6] == $past(first_timer_unit_do_in[6]))
    else $error("first timer lost pin 6");
  chk_second_timer_gate: assert property (cand_en[4][1:0] == 2'h0 // see [RULE6]
      && !first_timer_unit_en_in[4] && !second_timer_unit_chan_en_in[4]
      |=> pin_oe_q[4] == $past(port_v_direction_in[4]))
    else $error("disabled second timer channel took pin 4");
  chk_pin3_sda: assert property (cand_en[3][1:0] == 2'h0 && i2c_sda_en_in // see [RULE7]
      |=> pin_out[3] == $past(i2c_sda_do_in) && pin_oe_q[3] == $past(i2c_sda_oe_in))
    else $error("sda lost pin 3");
  chk_pin2_sck: assert property (cand_en[2][3:0] == 4'h0 && spi_en_in[1] // see [RULE8]
      |=> pin_out[2] == $past(spi_do_in[1]))
    else $error("sck lost pin 2");
  chk_pin1_pwm5: assert property (cand_en[1][2:0] == 3'h0 // see [RULE9]
      && pulse_channel_five_en_in
      |=> pin_out[1] == $past(pulse_channel_five_do_in) && pin_oe_q[1])
    else $error("pwm5 lost pin 1");
  chk_gpio_drive: assert property (cand_en[0] == 6'h00 && port_v_direction_in[0] // see [RULE11]
      |=> pin_out[0] == $past(latch_q[0]))
    else $error("output pin not driven from latch");
endmodule

/* sim/pvm_partner.sv */
// model of the peripherals and pads around port v
`timescale 1ns/100ps
module pvm_partner (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic step_in,
  input wire logic [1:0] sweep_in,
  input wire logic [2:0] rank_in,
  input wire logic [39:0] ren_in,
  input wire logic [51:0] rdo_in,
  input wire logic [7:0] cap_in,
  input wire logic [7:0] ext_in,
  input wire logic [7:0] do_in,
  input wire logic [7:0] oe_in,
  output logic [39:0] en_out,
  output logic [39:0] do_out,
  output logic [7:0] chan_out,
  output logic [3:0] oe_out,
  output logic [7:0] pin_out
);
  logic [39:0] sw;
  logic [39:0] cm;
  logic [2:0] k;
  always_comb begin
    k = rank_in;
    sw = {1'b0, k <= 3'h2, k <= 3'h4, k <= 3'h4, k <= 3'h3, k <= 3'h5, k <= 3'h3,
      k <= 3'h2, {8{k <= 3'h3}}, {8{k <= 3'h2}}, {8{k <= 3'h1}}, {8{k == 3'h0}}};
    // a capture pin has every output function withdrawn
    cm = {1'b0, cap_in[1], cap_in[2], cap_in[3], cap_in[1], cap_in[2], cap_in[3],
      cap_in[3], {4{cap_in}}};
  end
  // claims change only just after an edge
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      {en_out, do_out, chan_out, oe_out} <= '0;
    end else if (step_in) begin
      en_out <= (sweep_in[0] ? sw : ren_in) & ~cm;
      do_out <= rdo_in[39:0];
      oe_out <= rdo_in[43:40];
      chan_out <= sweep_in[0] ? {8{sweep_in[1]}} : rdo_in[51:44];
    end
  end
  // undriven pads take the level the board puts on them
  assign pin_out = (oe_in & do_in) | (~oe_in & ext_in);
endmodule

/* sim/test_port_v_pin_function_mux.sv */
// self-checking bench for the port v pin function mux
`timescale 1ns/100ps
module test_port_v_pin_function_mux;
  logic clk_in, reset_n_in, hsel_in, hwrite_in, step, hrdy, hresp;
  logic [1:0] htrans_in, sweep;
  logic [2:0] hsize_in, rank;
  logic [31:0] haddr_in, hwdata_in, rd, seed, cyc, hrd;
  logic [63:0] r1, r2, r3;
  logic [7:0] dir, ext, cap, lat, lvl, chan, pin_in, pout, poe8, plev;
  logic [39:0] ren, pen, pdo;
  logic [51:0] rdo;
  logic [15:0] e;
  logic [3:0] poe;
  int n_fail, n_tests;
  localparam logic [31:0] A = pvm_pkg::PVM_LATCH_ADDR;
  pvm_top u_pvm_top (.clk_in(clk_in), .reset_n_in(reset_n_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
    .hwdata_in(hwdata_in), .hready_in(hrdy), .hreadyout_out(hrdy), .hresp_out(hresp),
    .hrdata_out(hrd), .port_v_direction_in(dir), .pin_in(pin_in), .pin_out(pout),
    .pin_oe_out(poe8), .pin_level_out(plev),
    .stall_detect_unit_en_in(pen[7:0]), .stall_detect_unit_do_in(pdo[7:0]),
    .motor_pwm_en_in(pen[15:8]), .motor_pwm_do_in(pdo[15:8]),
    .first_timer_unit_en_in(pen[23:16]), .first_timer_unit_do_in(pdo[23:16]),
    .second_timer_unit_en_in(pen[31:24]), .second_timer_unit_chan_en_in(chan),
    .second_timer_unit_do_in(pdo[31:24]), .i2c_sda_en_in(pen[32]), .i2c_sda_do_in(pdo[32]),
    .i2c_sda_oe_in(poe[0]), .pulse_channel_seven_en_in(pen[33]),
    .pulse_channel_seven_do_in(pdo[33]), .pulse_channel_six_en_in(pen[34]),
    .pulse_channel_six_do_in(pdo[34]), .pulse_channel_five_en_in(pen[35]),
    .pulse_channel_five_do_in(pdo[35]), .spi_en_in(pen[38:36]), .spi_do_in(pdo[38:36]),
    .spi_oe_in(poe[3:1]));
  pvm_partner u_pvm_partner (.clk_in(clk_in), .reset_n_in(reset_n_in), .step_in(step),
    .sweep_in(sweep), .rank_in(rank), .ren_in(ren), .rdo_in(rdo), .cap_in(cap),
    .ext_in(ext), .do_in(pout), .oe_in(poe8), .en_out(pen), .do_out(pdo),
    .chan_out(chan), .oe_out(poe), .pin_out(pin_in));
  // expected {oe, value} per pin: walk each chain from the lowest priority up
  function automatic logic [15:0] exp_f(input logic [39:0] n, input logic [39:0] v,
      input logic [7:0] ce, input logic [3:0] o, input logic [7:0] la, input logic [7:0] di);
    logic [15:0] r;
    logic [5:0] ce6, cd6, co6;
    r = '0;
    for (int p = 0; p < 8; p++) begin
      ce6 = {4'h0, n[8 + p], n[p]};
      cd6 = {4'h0, v[8 + p], v[p]};
      co6 = 6'h3f;
      if (p == 6 || p == 4 || p == 2) begin
        ce6[3:2] = {n[24 + p] & ce[p], n[16 + p]};
        cd6[3:2] = {v[24 + p], v[16 + p]};
      end
      if (p == 3) begin
        ce6[4:2] = {n[36], n[33], n[32]};
        cd6[4:2] = {v[36], v[33], v[32]};
        co6[4:2] = {o[1], 1'b1, o[0]};
      end
      if (p == 2) begin
        ce6[5:4] = {n[34], n[37]};
        cd6[5:4] = {v[34], v[37]};
        co6[4] = o[2];
      end
      if (p == 1) begin
        ce6[3:2] = {n[35], n[38]};
        cd6[3:2] = {v[35], v[38]};
        co6[2] = o[3];
      end
      {r[8 + p], r[p]} = {di[p], la[p]};
      for (int s = 5; s >= 0; s--) begin
        if (ce6[s]) {r[8 + p], r[p]} = {co6[s], cd6[s]};
      end
    end
    return r;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    {hsel_in, htrans_in, haddr_in, hwrite_in, hsize_in} <= {1'b1, 2'h2, a, wr, 3'h2};
    @(posedge clk_in);
    while (hrdy !== 1'b1) @(posedge clk_in);
    {hsel_in, htrans_in, hwdata_in} <= {1'b0, 2'h0, wd};
    @(posedge clk_in);
    while (hrdy !== 1'b1) @(posedge clk_in);
    rd = hrd;
    chk({31'h0, hresp}, {31'h0, pvm_pkg::PVM_HRESP_OKAY});
  endtask
  task automatic draw();
    r1 = {$random(seed), $random(seed)};
    r2 = {$random(seed), $random(seed)};
    r3 = {$random(seed), $random(seed)};
    ren <= r1[39:0] & r2[39:0] & r3[63:24];
    rdo <= {r3[11:0], r2[63:24]};
    {dir, ext} <= r1[55:40];
    cap <= r1[63:56] & r3[23:16];
  endtask
  // hold claims long enough for the pad level to pass the synchroniser
  task automatic apply();
    step <= 1'b1;
    @(posedge clk_in);
    step <= 1'b0;
    repeat (6) @(posedge clk_in);
    e = exp_f(pen, pdo, chan, poe, lat, dir);
    lvl = (e[15:8] & e[7:0]) | (~e[15:8] & ext);
    chk(32'(poe8), 32'(e[15:8]));
    chk({24'h0, pout & e[15:8]}, {24'h0, e[7:0] & e[15:8]});
    chk({24'h0, plev}, {24'h0, lvl});
    bus(1'b0, A, 32'h0);
    chk(rd, {24'h0, (dir & lat) | (~dir & lvl)});
  endtask
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 32'h1;
    if (cyc == 32'h4e20) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    {seed, cyc, n_fail, n_tests} = {32'h5334, 32'h0, 32'h0, 32'h0};
    {hsel_in, hwrite_in, step, sweep, rank, htrans_in, hsize_in} = '0;
    {haddr_in, hwdata_in, dir, ext, cap, lat, ren, rdo} = '0;
    reset_n_in = 1'b0;
    repeat (3) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    chk({24'h0, poe8}, 32'h0);
    chk({31'h0, hrdy}, 32'h1);
    dir <= 8'hff;
    bus(1'b0, A, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, A, 32'hffff_ffa5);
    bus(1'b0, A, 32'h0);
    chk(rd, 32'h0000_00a5);
    bus(1'b1, A + 32'h4, 32'h5a);
    bus(1'b0, A + 32'h4, 32'h0);
    chk(rd, 32'h0);
    lat = 8'ha5;
    // strip the chains one priority level at a time, timer channel on and off
    for (int i = 0; i < 14; i++) begin
      draw();
      {sweep, rank} <= {i[0], 1'b1, 3'(i / 2)};
      cap <= 8'h00;
      // corner cases: all pins input, then all pins output, for the top ranks
      if (i < 4) begin
        dir <= {8{i[1]}};
      end
      apply();
    end
    sweep <= 2'h0;
    repeat (150) begin
      draw();
      if (r3[20]) begin
        lat = r3[31:24];
        bus(1'b1, A, {24'h0, r3[31:24]});
      end
      apply();
    end
    test_done();
  end
endmodule
